// [common/adg_regs.vh]
`ifndef ADG_REGS_VH
`define ADG_REGS_VH
// Functional notes
// [R1] Per-channel third-order sinc filter, then decimate
// [R2] One shared decimation ratio for all channels
// [R3] Modulator rate is clock/2, one bit per cycle
// [R4] One word per channel every N modulator cycles
// [R5] Step input settles within three output periods
// [R6] First word only after initial settling interval
// [R7] Select pin low: clock pin is input
// [R8] Select high: clock pin driven only when enabled
// [R9] Host should stop external clock in power-down
// [R10] Four port pins, each with own direction bit
// [R11] Level read returns actual pin level
// [R12] Level write ignored on input pins
// [R13] All port pins are inputs after reset
// [R14] Host drives input pins, never floating
// [R15] Codes 110/111 route bias return to P/N
// [R16] Code 010 with measure bit: bias measurement
// [R17] Separate positive and negative sense enables
// [R18] Excitation may be off while sensing stays on
// [R19] Reference buffer off by default after wake-up

// ====
// Register byte offsets
`define ADG_OFS_SETUP1 6'h00
`define ADG_OFS_SETUP3 6'h04
`define ADG_OFS_CTRL 6'h08
`define ADG_OFS_CHMUX 6'h0C
`define ADG_OFS_SENSP 6'h10
`define ADG_OFS_SENSN 6'h14
`define ADG_OFS_PORT 6'h18
`define ADG_OFS_STATUS 6'h1C
`define ADG_OFS_DATA 6'h20

// ====
// Field positions
`define ADG_DR_MSB 2
`define ADG_DR_LSB 0
`define ADG_CLKEN_BIT 5
`define ADG_REFBUF_BIT 7
`define ADG_BMEAS_BIT 4
`define ADG_START_BIT 0
`define ADG_EXCITE_BIT 1
`define ADG_OVR_BIT 1

// ====
// Reset values
`define ADG_RST_SETUP1 8'h06
`define ADG_RST_SETUP3 8'h00
`define ADG_RST_CTRL 8'h02
`define ADG_RST_DIR 4'hF

// ====
// Codes and counts
`define ADG_MUX_BIAS_P 3'h6
`define ADG_MUX_BIAS_N 3'h7
`define ADG_MUX_BMEAS 3'h2
`define ADG_DR_MAX 3'h6
`define ADG_SETTLE_SKIP 2'h3
`define ADG_NMIN_M1 12'h03F
`endif

// [design/adg_fifo.v]
module adg_fifo #(
    parameter W = 27,
    parameter D = 4,
    parameter AW = 2
) (
    input wire i_mclk,
    input wire i_resetn,
    input wire i_ce,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data
);
    // ====
    // Storage and pointers
    reg [W-1:0] mem_ff [0:D-1]; // Word slots
    reg [AW-1:0] wr_ff; // Write index
    reg [AW-1:0] rd_ff; // Read index
    reg [AW:0] cnt_ff; // Fill level
    wire push = i_in_valid & o_in_ready;
    wire pop = o_out_valid & i_out_ready;

    assign o_in_ready = (cnt_ff != D[AW:0]);
    assign o_out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign o_out_data = mem_ff[rd_ff];

    // Pointer wrap is explicit so D need not be a power of two
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ff <= {AW{1'b0}};
            rd_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else if (i_ce) begin
            if (push) begin
                wr_ff <= (wr_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
            end
            if (push & ~pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop & ~push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end

    // Data slots carry no reset
    always @(posedge i_mclk) begin
        if (i_ce && push) begin
            mem_ff[wr_ff] <= i_in_data;
        end
    end
endmodule

// [design/adg_sinc3.v]
module adg_sinc3 #(
    parameter W = 37
) (
    input wire i_mclk,
    input wire i_resetn,
    input wire i_step,
    input wire i_clear,
    input wire i_dump,
    input wire i_bit,
    output wire [W-1:0] o_word
);
    // ====
    // Integrators and comb delays
    reg [W-1:0] int1_ff, int2_ff, int3_ff; // Running sums
    reg [W-1:0] dly1_ff, dly2_ff, dly3_ff; // Comb memories
    reg [W-1:0] word_ff; // Latest decimated word
    wire [W-1:0] comb1 = int3_ff - dly1_ff;
    wire [W-1:0] comb2 = comb1 - dly2_ff;
    wire [W-1:0] comb3 = comb2 - dly3_ff;

    assign o_word = word_ff;

    // Wrapping arithmetic is exact as long as W covers N cubed
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            {int1_ff, int2_ff, int3_ff, dly1_ff, dly2_ff, dly3_ff} <= {(6*W){1'b0}};
            word_ff <= {W{1'b0}};
        end else if (i_clear) begin
            {int1_ff, int2_ff, int3_ff, dly1_ff, dly2_ff, dly3_ff} <= {(6*W){1'b0}};
        end else begin
            // One input bit per modulator step
            if (i_step) begin
                int1_ff <= int1_ff + {{(W-1){1'b0}}, i_bit}; // [R1]
                int2_ff <= int2_ff + int1_ff;
                int3_ff <= int3_ff + int2_ff;
            end
            // Comb runs at the output rate
            if (i_dump) begin
                dly1_ff <= int3_ff;
                dly2_ff <= comb1;
                dly3_ff <= comb2;
                word_ff <= comb3; // [R1]
            end
        end
    end
endmodule

// [design/adg_top.v]
`include "adg_regs.vh"

module adg_top #(
    parameter NCH = 8,
    parameter FW = 37,
    parameter FIFO_D = 4
) (
    input wire i_mclk,
    input wire i_resetn,
    input wire i_ce,
    // Avalon-MM slave
    input wire [5:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output wire [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // Converter side
    input wire i_start,
    input wire [NCH-1:0] i_mod_bits,
    // Clock pin
    input wire i_clock_source_select_pin,
    input wire i_osc_level,
    output wire o_clk_internal,
    output wire o_clk_pin_out,
    output wire o_clk_pin_oe_n,
    // Port pins
    input wire [3:0] i_port_in,
    output wire [3:0] o_port_out,
    output wire [3:0] o_port_oe_n,
    // Analog controls
    output wire [NCH-1:0] o_bias_return_input_pin_to_pos,
    output wire [NCH-1:0] o_bias_return_input_pin_to_neg,
    output wire [NCH-1:0] o_bias_measure,
    output wire [NCH-1:0] o_sense_pos_en,
    output wire [NCH-1:0] o_sense_neg_en,
    output wire o_excite_en,
    output wire o_refbuf_on
);
    // ====
    // Local sizes
    localparam DW = 24; // Output word width
    localparam CW = 3; // Channel index width
    localparam QW = CW + DW; // Buffered word width

    // ====
    // Register state
    reg [7:0] setup1_ff; // Rate and clock-out enable
    reg [7:0] setup3_ff; // Reference and bias measure
    reg [7:0] ctrl_ff; // Start and excitation
    reg [3*NCH-1:0] mux_ff; // Per-channel mux codes
    reg [NCH-1:0] sensp_ff; // Positive sense enables
    reg [NCH-1:0] sensn_ff; // Negative sense enables
    reg [3:0] dir_ff; // 1 = input
    reg [3:0] lvl_ff; // Output levels
    reg ovr_ff; // Frame lost, sticky
    reg settled_ff; // First word delivered
    reg wreq_ff; // Waitrequest
    reg [31:0] rdata_ff; // Read data

    // ====
    // Output flops
    reg clk_int_ff; // Internal clock chosen
    reg clk_out_ff; // Oscillator copy
    reg clk_oe_n_ff; // Clock pin enable
    reg [NCH-1:0] to_pos_ff; // Bias return to P
    reg [NCH-1:0] to_neg_ff; // Bias return to N
    reg [NCH-1:0] bmeas_ff; // Bias measurement
    reg excite_ff; // Excitation sources
    reg refbuf_ff; // Reference buffer on

    // ====
    // Converter control state
    reg mod_ph_ff; // Modulator phase
    reg [11:0] dec_cnt_ff; // Modulator cycles in period
    reg run_ff; // Previous run level
    reg [1:0] skip_ff; // Periods still discarded
    reg dump_d_ff; // Word ready one cycle later
    reg busy_ff; // Frame being pushed
    reg [CW-1:0] idx_ff; // Channel being pushed
    reg [DW*NCH-1:0] frame_ff; // Captured words

    // ====
    // Bus decode
    wire acc = (i_avs_read | i_avs_write) & ~wreq_ff; // Accept edge
    wire acc_wr = acc & i_avs_write;
    wire acc_rd = acc & i_avs_read;
    wire hit_data = (i_avs_address == `ADG_OFS_DATA);

    assign o_avs_readdata = rdata_ff;
    assign o_avs_waitrequest = wreq_ff;
    assign o_clk_internal = clk_int_ff;
    assign o_clk_pin_out = clk_out_ff;
    assign o_clk_pin_oe_n = clk_oe_n_ff;
    assign o_port_out = lvl_ff;
    assign o_port_oe_n = dir_ff;
    assign o_bias_return_input_pin_to_pos = to_pos_ff;
    assign o_bias_return_input_pin_to_neg = to_neg_ff;
    assign o_bias_measure = bmeas_ff;
    assign o_sense_pos_en = sensp_ff;
    assign o_sense_neg_en = sensn_ff;
    assign o_excite_en = excite_ff;
    assign o_refbuf_on = refbuf_ff;

    // ====
    // Rate selection
    // Code 7 is reserved and treated as the slowest rate
    wire [2:0] dr_code = setup1_ff[`ADG_DR_MSB:`ADG_DR_LSB];
    wire [2:0] dr_eff = (dr_code > `ADG_DR_MAX) ? `ADG_DR_MAX : dr_code; // [R2]
    wire [11:0] n_m1 = (`ADG_NMIN_M1 << dr_eff) | `ADG_NMIN_M1;
    wire [4:0] shamt = {1'b0, dr_eff, 1'b0} + {2'b00, dr_eff};

    // ====
    // Start and modulator timing
    wire run = i_start | ctrl_ff[`ADG_START_BIT];
    wire start_rise = run & ~run_ff;
    wire flt_clear = i_ce & (~run | start_rise); // [R6]
    wire step = i_ce & run & mod_ph_ff; // [R3]
    wire dump = step & (dec_cnt_ff == n_m1); // [R4]

    // ====
    // Buffer handshake
    wire q_in_ready;
    wire q_out_valid;
    wire [QW-1:0] q_out_data;
    wire q_pop = i_ce & acc_rd & hit_data;
    wire [DW-1:0] push_word = frame_ff[idx_ff*DW +: DW];

    // ====
    // Filter bank
    wire [DW*NCH-1:0] norm_words; // Scaled words, all channels
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            wire [FW-1:0] raw;
            wire [FW-1:0] sh = raw >> shamt;
            adg_sinc3 #(
                .W(FW)
            ) u_sinc (
                .i_mclk(i_mclk),
                .i_resetn(i_resetn),
                .i_step(step),
                .i_clear(flt_clear),
                .i_dump(dump),
                .i_bit(i_mod_bits[g]),
                .o_word(raw)
            );
            // Full scale is N cubed; after shifting it fits 19 bits
            assign norm_words[g*DW +: DW] = {sh[18:0], 5'h00}; // [R1]
        end
    endgenerate

    // ====
    // Word buffer
    adg_fifo #(
        .W(QW),
        .D(FIFO_D),
        .AW(2)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_in_valid(busy_ff),
        .o_in_ready(q_in_ready),
        .i_in_data({idx_ff, push_word}),
        .o_out_valid(q_out_valid),
        .i_out_ready(q_pop),
        .o_out_data(q_out_data)
    );

    // ====
    // Modulator phase, decimation counter and settling
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            mod_ph_ff <= 1'b0;
            dec_cnt_ff <= 12'h000;
            run_ff <= 1'b0;
            skip_ff <= `ADG_SETTLE_SKIP;
            dump_d_ff <= 1'b0;
        end else if (i_ce) begin
            run_ff <= run;
            dump_d_ff <= dump;
            if (~run | start_rise) begin
                // Restart aligns phase, counter and discard count
                mod_ph_ff <= 1'b0;
                dec_cnt_ff <= 12'h000;
                skip_ff <= `ADG_SETTLE_SKIP; // [R6]
            end else begin
                mod_ph_ff <= ~mod_ph_ff; // [R3]
                if (dump) begin
                    dec_cnt_ff <= 12'h000; // [R4]
                end else if (step) begin
                    dec_cnt_ff <= dec_cnt_ff + 12'h001;
                end
                // Three periods fill the filter after a restart
                if (dump_d_ff && skip_ff != 2'h0) begin
                    skip_ff <= skip_ff - 2'h1; // [R5]
                end
            end
        end
    end

    // ====
    // Frame capture and push into the buffer
    // A frame arriving while the last one is still being pushed into the buffer is dropped
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_ff <= 1'b0;
            idx_ff <= {CW{1'b0}};
            frame_ff <= {(DW*NCH){1'b0}};
            settled_ff <= 1'b0;
        end else if (i_ce) begin
            if (~run | start_rise) begin
                settled_ff <= 1'b0;
            end else if (dump_d_ff && skip_ff == 2'h0 && !busy_ff) begin
                frame_ff <= norm_words; // [R4]
                busy_ff <= 1'b1;
                idx_ff <= {CW{1'b0}};
                settled_ff <= 1'b1; // [R6]
            end
            if (busy_ff && q_in_ready) begin
                // Buffer stall holds the walk in place
                if (idx_ff == NCH[CW-1:0] - 1'b1) begin
                    busy_ff <= 1'b0;
                end else begin
                    idx_ff <= idx_ff + 1'b1;
                end
            end
        end
    end

    // ====
    // Register writes
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            setup1_ff <= `ADG_RST_SETUP1;
            setup3_ff <= `ADG_RST_SETUP3; // [R19]
            ctrl_ff <= `ADG_RST_CTRL;
            mux_ff <= {(3*NCH){1'b0}};
            sensp_ff <= {NCH{1'b0}};
            sensn_ff <= {NCH{1'b0}};
            dir_ff <= `ADG_RST_DIR; // [R13]
            lvl_ff <= 4'h0;
        end else if (i_ce && acc_wr) begin
            case (i_avs_address)
                `ADG_OFS_SETUP1: begin
                    setup1_ff <= i_avs_writedata[7:0]; // [R2]
                end
                `ADG_OFS_SETUP3: setup3_ff <= i_avs_writedata[7:0];
                `ADG_OFS_CTRL: ctrl_ff <= i_avs_writedata[7:0];
                `ADG_OFS_CHMUX: mux_ff <= i_avs_writedata[3*NCH-1:0];
                `ADG_OFS_SENSP: begin
                    sensp_ff <= i_avs_writedata[NCH-1:0]; // [R17]
                end
                `ADG_OFS_SENSN: begin
                    sensn_ff <= i_avs_writedata[NCH-1:0]; // [R17]
                end
                `ADG_OFS_PORT: begin
                    dir_ff <= i_avs_writedata[3:0]; // [R10]
                    // Input pins keep their old output level
                    lvl_ff <= (lvl_ff & dir_ff) | (i_avs_writedata[7:4] & ~dir_ff); // [R12]
                end
                default: begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end
    end

    // ====
    // Overrun flag: set wins over a clear in the same cycle
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ovr_ff <= 1'b0;
        end else if (i_ce) begin
            if (dump_d_ff && skip_ff == 2'h0 && busy_ff && run && !start_rise) begin
                ovr_ff <= 1'b1;
            end else if (acc_wr && i_avs_address == `ADG_OFS_STATUS &&
                         i_avs_writedata[`ADG_OVR_BIT]) begin
                ovr_ff <= 1'b0;
            end
        end
    end

    // ====
    // Bus answer: one wait cycle, then one ready cycle
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wreq_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else if (i_ce) begin
            wreq_ff <= ~((i_avs_read | i_avs_write) & wreq_ff);
            if (i_avs_read & wreq_ff) begin
                case (i_avs_address)
                    `ADG_OFS_SETUP1: rdata_ff <= {24'h000000, setup1_ff};
                    `ADG_OFS_SETUP3: rdata_ff <= {24'h000000, setup3_ff};
                    `ADG_OFS_CTRL: rdata_ff <= {24'h000000, ctrl_ff};
                    `ADG_OFS_CHMUX: rdata_ff <= {{(32-3*NCH){1'b0}}, mux_ff};
                    `ADG_OFS_SENSP: rdata_ff <= {{(32-NCH){1'b0}}, sensp_ff};
                    `ADG_OFS_SENSN: rdata_ff <= {{(32-NCH){1'b0}}, sensn_ff};
                    `ADG_OFS_PORT: begin
                        // Levels are the pins themselves
                        rdata_ff <= {24'h000000, i_port_in, dir_ff}; // [R11]
                    end
                    `ADG_OFS_STATUS: begin
                        rdata_ff <= {28'h0000000, run, settled_ff, ovr_ff, q_out_valid};
                    end
                    `ADG_OFS_DATA: begin
                        // Head word; popped at the accept edge
                        rdata_ff <= {q_out_valid, {(31-QW){1'b0}}, q_out_data};
                    end
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ====
    // Clock pin and analog control outputs
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            clk_int_ff <= 1'b0;
            clk_out_ff <= 1'b0;
            clk_oe_n_ff <= 1'b1;
            excite_ff <= 1'b0;
            refbuf_ff <= 1'b0;
        end else if (i_ce) begin
            // Low select: pin is an input, enable bit ignored
            clk_int_ff <= i_clock_source_select_pin; // [R7]
            clk_out_ff <= i_osc_level & i_clock_source_select_pin;
            clk_oe_n_ff <= ~(i_clock_source_select_pin & setup1_ff[`ADG_CLKEN_BIT]); // [R8]
            // Excitation gated apart from sense enables
            excite_ff <= ctrl_ff[`ADG_EXCITE_BIT]; // [R18]
            refbuf_ff <= setup3_ff[`ADG_REFBUF_BIT]; // [R19]
        end
    end

    // ====
    // Per-channel mux decode
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_mux
            always @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    to_pos_ff[g] <= 1'b0;
                    to_neg_ff[g] <= 1'b0;
                    bmeas_ff[g] <= 1'b0;
                end else if (i_ce) begin
                    to_pos_ff[g] <= (mux_ff[3*g +: 3] == `ADG_MUX_BIAS_P); // [R15]
                    to_neg_ff[g] <= (mux_ff[3*g +: 3] == `ADG_MUX_BIAS_N); // [R15]
                    bmeas_ff[g] <= (mux_ff[3*g +: 3] == `ADG_MUX_BMEAS) &
                                   setup3_ff[`ADG_BMEAS_BIT]; // [R16]
                end
            end
        end
    endgenerate
endmodule

// [testbench/adg_top_props.sv]
module adg_top_props #(
    parameter NCH = 8
) (
    input wire i_mclk,
    input wire i_resetn,
    input wire i_ce,
    input wire [5:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire o_avs_waitrequest,
    input wire i_clock_source_select_pin,
    input wire o_clk_internal,
    input wire o_clk_pin_oe_n,
    input wire [3:0] o_port_out,
    input wire [3:0] o_port_oe_n,
    input wire [NCH-1:0] o_bias_return_input_pin_to_pos,
    input wire [NCH-1:0] o_bias_return_input_pin_to_neg,
    input wire [NCH-1:0] o_bias_measure,
    input wire [NCH-1:0] o_sense_pos_en,
    input wire [NCH-1:0] o_sense_neg_en,
    input wire o_excite_en,
    input wire o_refbuf_on
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    // ====
    // Shadow of committed writes
    logic [7:0] s1_ff, s3_ff, ctl_ff, sp_ff, sn_ff;
    logic [3:0] dir_ff; // Port direction, 1 = input
    logic [3*NCH-1:0] mux_ff;
    logic [1:0] calm_ff; // Edges since last write; mirrors lag a flop
    logic [NCH-1:0] e_pos, e_neg, e_meas;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_ff <= 8'h06;
            s3_ff <= 8'h00;
            ctl_ff <= 8'h02;
            sp_ff <= 8'h00;
            sn_ff <= 8'h00;
            dir_ff <= 4'hF;
            mux_ff <= '0;
            calm_ff <= 2'h0;
        end else if (i_ce) begin
            calm_ff <= (calm_ff == 2'h3) ? 2'h3 : calm_ff + 2'h1;
            if (i_avs_write && !o_avs_waitrequest) begin
                calm_ff <= 2'h0;
                case (i_avs_address)
                    6'h00: s1_ff <= i_avs_writedata[7:0];
                    6'h04: s3_ff <= i_avs_writedata[7:0];
                    6'h08: ctl_ff <= i_avs_writedata[7:0];
                    6'h0C: mux_ff <= i_avs_writedata[3*NCH-1:0];
                    6'h10: sp_ff <= i_avs_writedata[7:0];
                    6'h14: sn_ff <= i_avs_writedata[7:0];
                    6'h18: dir_ff <= i_avs_writedata[3:0];
                    default: ;
                endcase
            end
        end
    end
    // Expected analog switch controls per channel
    always_comb begin
        for (int g = 0; g < NCH; g++) begin
            e_pos[g] = (mux_ff[3*g +: 3] == 3'h6);
            e_neg[g] = (mux_ff[3*g +: 3] == 3'h7);
            e_meas[g] = (mux_ff[3*g +: 3] == 3'h2) && s3_ff[4];
        end
    end
    // ====
    // Properties
    a_wait_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("wait low too long");
    a_answer_next_edge: assert property (i_ce && (i_avs_read || i_avs_write)
        && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("bus answer late");
    a_sel_low_input: assert property (!i_clock_source_select_pin |=> !o_clk_internal && o_clk_pin_oe_n)
        else $error("pin driven, select low");
    a_sel_high_osc: assert property (i_clock_source_select_pin |=> o_clk_internal)
        else $error("internal clock not chosen");
    a_clk_pin_enable: assert property (calm_ff == 2'h3 && $past(i_clock_source_select_pin) |-> o_clk_pin_oe_n == !s1_ff[5])
        else $error("clock pin enable wrong");
    a_dir_mirror: assert property (calm_ff == 2'h3 |-> o_port_oe_n == dir_ff)
        else $error("port direction wrong");
    a_input_level_held: assert property (((o_port_oe_n & $past(o_port_oe_n)) & (o_port_out ^ $past(o_port_out))) == 4'h0)
        else $error("input pin level changed");
    a_sense_enables: assert property (calm_ff == 2'h3 |-> o_sense_pos_en == sp_ff[NCH-1:0] && o_sense_neg_en == sn_ff[NCH-1:0])
        else $error("sense enables wrong");
    a_bias_routing: assert property (calm_ff == 2'h3 |-> o_bias_return_input_pin_to_pos == e_pos && o_bias_return_input_pin_to_neg == e_neg)
        else $error("bias routing wrong");
    a_bias_measure: assert property (calm_ff == 2'h3 |-> o_bias_measure == e_meas)
        else $error("bias measure wrong");
    a_excite_refbuf: assert property (calm_ff == 2'h3 |-> o_excite_en == ctl_ff[1] && o_refbuf_on == s3_ff[7])
        else $error("excitation or buffer wrong");
endmodule

bind adg_top adg_top_props #(.NCH(NCH)) u_adg_top_props (.i_mclk, .i_resetn, .i_ce,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_waitrequest,
    .i_clock_source_select_pin, .o_clk_internal, .o_clk_pin_oe_n, .o_port_out, .o_port_oe_n,
    .o_bias_return_input_pin_to_pos, .o_bias_return_input_pin_to_neg, .o_bias_measure, .o_sense_pos_en, .o_sense_neg_en,
    .o_excite_en, .o_refbuf_on);

// [testbench/adg_far_model.sv]
module adg_far_model #(
    parameter NCH = 8
) (
    input wire i_mclk,
    input wire [3:0] i_port_out,
    input wire [3:0] i_port_oe_n,
    input wire [3:0] i_ext_drive,
    output logic [3:0] o_port_in,
    output logic [NCH-1:0] o_mod_bits,
    output logic o_osc_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Far end always drives pins left as inputs, never floats them
    assign o_port_in = (i_port_oe_n & i_ext_drive) | (~i_port_oe_n & i_port_out);
    // Even channels at full scale, odd channels at zero
    assign o_mod_bits = {(NCH / 2){2'b01}};
    // Oscillator toggles every clock; no power-down is modelled, so it never stops
    initial o_osc_level = 1'b0;
    always @(posedge i_mclk) o_osc_level <= ~o_osc_level;
endmodule

// [testbench/tb_adg_top.sv]
module tb_adg_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Design pins
    logic i_mclk, i_resetn, i_ce, i_avs_read, i_avs_write, i_start, i_clock_source_select_pin;
    logic [5:0] i_avs_address;
    logic [31:0] i_avs_writedata, q;
    logic [3:0] ext_drive; // Far-end level on input pins
    wire [31:0] o_avs_readdata;
    wire o_avs_waitrequest, i_osc_level, o_clk_internal, o_clk_pin_out, o_clk_pin_oe_n;
    wire o_excite_en, o_refbuf_on;
    wire [7:0] i_mod_bits, o_bias_return_input_pin_to_pos, o_bias_return_input_pin_to_neg, o_bias_measure;
    wire [7:0] o_sense_pos_en, o_sense_neg_en;
    wire [3:0] i_port_in, o_port_out, o_port_oe_n;
    int fails, check_count, n;
    logic [7:0] pw[2] = '{8'hF3, 8'h02}; // Port writes
    logic [7:0] pr[2] = '{8'h23, 8'h22}; // Port reads with ext_drive A
    adg_top #(.NCH(8), .FW(37), .FIFO_D(4)) u_adg_top (.i_mclk, .i_resetn, .i_ce,
        .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
        .o_avs_waitrequest, .i_start, .i_mod_bits, .i_clock_source_select_pin, .i_osc_level,
        .o_clk_internal, .o_clk_pin_out, .o_clk_pin_oe_n, .i_port_in, .o_port_out, .o_port_oe_n,
        .o_bias_return_input_pin_to_pos, .o_bias_return_input_pin_to_neg, .o_bias_measure, .o_sense_pos_en, .o_sense_neg_en,
        .o_excite_en, .o_refbuf_on);
    adg_far_model #(.NCH(8)) u_adg_far_model (.i_mclk, .i_port_out(o_port_out),
        .i_port_oe_n(o_port_oe_n), .i_ext_drive(ext_drive), .o_port_in(i_port_in),
        .o_mod_bits(i_mod_bits), .o_osc_level(i_osc_level));
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    // ====
    // One Avalon access, after an idle edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_mclk);
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_address <= a;
        i_avs_writedata <= d;
        do begin
            @(posedge i_mclk);
            k++;
        end while (o_avs_waitrequest !== 1'b0 && k < 40);
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        if (k >= 40) fails++;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ====
    // Main sequence
    initial begin
        {i_resetn, i_avs_read, i_avs_write, i_start, i_clock_source_select_pin} = 5'h00;
        i_ce = 1'b1;
        i_avs_address = 6'h00;
        i_avs_writedata = 32'h0;
        ext_drive = 4'hA;
        repeat (8) @(posedge i_mclk);
        i_resetn <= 1'b1;
        bus(0, 6'h00, 0);
        chk("setup1", 32'h06, q);
        bus(0, 6'h18, 0);
        chk("port reset", 32'hAF, q);
        chk("excite reset", 1, o_excite_en);
        chk("refbuf reset", 0, o_refbuf_on);
        for (int i = 0; i < 2; i++) begin
            bus(1, 6'h18, {24'h0, pw[i]});
            bus(0, 6'h18, 0);
            chk("port read", {24'h0, pr[i]}, q);
        end
        bus(1, 6'h00, 32'h20);
        repeat (3) @(posedge i_mclk);
        chk("clk oe sel low", 1, o_clk_pin_oe_n);
        chk("clk out sel low", 0, o_clk_pin_out);
        i_clock_source_select_pin <= 1'b1;
        repeat (3) @(posedge i_mclk);
        chk("clk oe enabled", 0, o_clk_pin_oe_n);
        bus(1, 6'h00, 32'h00);
        repeat (3) @(posedge i_mclk);
        chk("clk oe disabled", 1, o_clk_pin_oe_n);
        bus(1, 6'h0C, 32'hBE);
        bus(1, 6'h04, 32'h90);
        bus(1, 6'h10, 32'hA5);
        bus(1, 6'h14, 32'h3C);
        bus(1, 6'h08, 32'h00);
        repeat (3) @(posedge i_mclk);
        chk("to pos", 1, o_bias_return_input_pin_to_pos);
        chk("to neg", 2, o_bias_return_input_pin_to_neg);
        chk("measure", 4, o_bias_measure);
        chk("refbuf", 1, o_refbuf_on);
        chk("sense", 32'hA53C, {o_sense_pos_en, o_sense_neg_en});
        chk("excite off", 0, o_excite_en);
        bus(0, 6'h3C, 0);
        chk("unmapped", 0, q);
        i_start <= 1'b1;
        repeat (400) @(posedge i_mclk);
        bus(0, 6'h1C, 0);
        chk("early empty", 0, q & 32'h7);
        for (int g = 0; g < 8; g++) begin
            n = 0;
            do begin
                bus(0, 6'h20, 0);
                n++;
            end while (q[31] !== 1'b1 && n < 200);
            chk("data", {5'h10, g[2:0], g[0] ? 24'h0 : 24'h800000}, q);
        end
        repeat (600) @(posedge i_mclk);
        bus(0, 6'h1C, 0);
        chk("overrun", 32'hF, q & 32'hF);
        i_start <= 1'b0;
        bus(1, 6'h1C, 32'h2);
        for (int i = 0; i < 12; i++) bus(0, 6'h20, 0);
        bus(0, 6'h1C, 0);
        chk("drained", 0, q & 32'hF);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        fails++;
        test_done;
    end
endmodule
